// File: core/dbw_pkg.sv
package dbw_pkg;
	// Byte addresses: the printed register number is a word index
	localparam logic [7:0] DBW_IDX_SEC_BW = 8'h66;
	localparam logic [7:0] DBW_IDX_LOCKED_BW = 8'h67;
	localparam logic [7:0] DBW_IDX_ACQ_BW = 8'h68;
	localparam logic [7:0] DBW_IDX_BW_SEL = 8'h3b;
	localparam int DBW_ADDR_W = 12;
	localparam logic [11:0] DBW_ADDR_SEC_BW = {2'h0, DBW_IDX_SEC_BW, 2'h0};
	localparam logic [11:0] DBW_ADDR_LOCKED_BW = {2'h0, DBW_IDX_LOCKED_BW, 2'h0};
	localparam logic [11:0] DBW_ADDR_ACQ_BW = {2'h0, DBW_IDX_ACQ_BW, 2'h0};
	localparam logic [11:0] DBW_ADDR_BW_SEL = {2'h0, DBW_IDX_BW_SEL, 2'h0};
	localparam logic [1:0] DBW_RST_SEC_BW = 2'h0;
	localparam logic [3:0] DBW_RST_LOCKED_BW = 4'h0;
	localparam logic [3:0] DBW_RST_ACQ_BW = 4'hf;
	localparam logic DBW_RST_AUTO_SW = 1'b0;
	localparam int DBW_AUTO_SW_BIT = 7;
	// Secondary path effective codes
	localparam logic [1:0] DBW_SEC_70HZ = 2'h2;
	// Main path codes
	localparam logic [3:0] DBW_MAIN_LO = 4'h8;
	localparam logic [3:0] DBW_MAIN_HI = 4'hd;
	localparam logic [3:0] DBW_MAIN_18HZ = 4'hf;
	localparam logic [3:0] DBW_MAIN_35HZ = 4'h0;
	localparam logic [3:0] DBW_MAIN_70HZ = 4'h1;
endpackage

// File: core/dbw_regs.sv
`timescale 1ns/1ps
// Summary of operation
// R1 - Secondary bandwidth bits [1:0]: 18, 35, 70 Hz; code 11 unused; resets zero.
// R2 - Locked bandwidth bits [3:0]: codes 1000..1101 give 0.3 to 8 Hz.
// R3 - Acquire bandwidth bits [3:0]: 1000..1101, 1111, 0000, 0001 valid; upper bits unused.
// R4 - Acquire bandwidth register is read/write, resets to 0x0f.
// R5 - Bit 7 of register 3B chooses locked-only or automatic bandwidth switching.
// R6 - Unused codes stored as written, applied as nearest defined; unused bits read zero.
module dbw_regs
	import dbw_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [DBW_ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	// Loop state
	input wire logic i_main_locked,
	// Bandwidth selects to the loop filters
	output logic [1:0] o_secondary_loop_bw_sel,
	output logic [3:0] o_main_loop_bw_sel,
	output logic o_main_loop_bw_is_acquire
);

	// Register bank: values as software wrote them
	logic [1:0] sec_bw_ff;
	logic [1:0] nxt_sec_bw;
	logic [3:0] lock_bw_ff;
	logic [3:0] nxt_lock_bw;
	logic [3:0] acq_bw_ff;
	logic [3:0] nxt_acq_bw;
	logic auto_sw_ff;
	logic nxt_auto_sw;

	// Bus answer
	logic pready_ff;
	logic nxt_pready;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	logic pslverr_ff;
	logic nxt_pslverr;

	// Settings applied to the loop filters
	logic [1:0] sec_sel_ff;
	logic [1:0] nxt_sec_sel;
	logic [3:0] main_sel_ff;
	logic [3:0] nxt_main_sel;
	logic is_acq_ff;
	logic nxt_is_acq;

	// Decoded request
	logic acc;
	logic wr_acc;
	logic rd_acc;
	logic hit;
	logic wr_sec;
	logic wr_lock;
	logic wr_acq;
	logic wr_sel;

	// Effective main path codes before the lock state picks one
	logic [3:0] lock_eff;
	logic [3:0] acq_eff;
	logic use_acq;

	// True when the byte address falls on an implemented word
	function automatic logic dbw_is_mapped(input logic [DBW_ADDR_W-1:0] addr);
		logic r;
		r = 1'b0;
		case (addr)
			DBW_ADDR_SEC_BW: begin
				r = 1'b1;
			end
			DBW_ADDR_LOCKED_BW: begin
				r = 1'b1;
			end
			DBW_ADDR_ACQ_BW: begin
				r = 1'b1;
			end
			DBW_ADDR_BW_SEL: begin
				r = 1'b1;
			end
			default: begin
				r = 1'b0;
			end
		endcase
		return r;
	endfunction

	// Write strobe for one word; a write with lane 0 disabled changes nothing
	function automatic logic dbw_wr_hit(
		input logic wr,
		input logic [DBW_ADDR_W-1:0] addr,
		input logic [DBW_ADDR_W-1:0] reg_addr
	);
		return wr && (addr == reg_addr);
	endfunction

	// Read view of the bank; unused bit positions and unmapped words read zero
	function automatic logic [31:0] dbw_read_word(
		input logic [DBW_ADDR_W-1:0] addr,
		input logic [1:0] sec_bw,
		input logic [3:0] lock_bw,
		input logic [3:0] acq_bw,
		input logic auto_sw
	);
		logic [31:0] r;
		r = 32'h0;
		case (addr)
			DBW_ADDR_SEC_BW: begin
				r = {30'h0, sec_bw}; // [R1] [R6]
			end
			DBW_ADDR_LOCKED_BW: begin
				r = {28'h0, lock_bw}; // [R2] [R6]
			end
			DBW_ADDR_ACQ_BW: begin
				r = {28'h0, acq_bw}; // [R3] [R4]
			end
			DBW_ADDR_BW_SEL: begin
				r = 32'h0;
				r[DBW_AUTO_SW_BIT] = auto_sw; // [R5]
			end
			default: begin
				r = 32'h0;
			end
		endcase
		return r;
	endfunction

	// Code 11 has no rate of its own; the nearest defined rate is 70 Hz
	function automatic logic [1:0] dbw_sec_fix(input logic [1:0] code);
		logic [1:0] r;
		r = code;
		case (code)
			2'h0: begin
				r = code;
			end
			2'h1: begin
				r = code;
			end
			2'h2: begin
				r = code;
			end
			2'h3: begin
				r = DBW_SEC_70HZ; // [R1] [R6]
			end
			default: begin
				r = code;
			end
		endcase
		return r;
	endfunction

	// Map each main path code onto the setting the loop filter applies;
	// 1110 sits next to 8 Hz, 0010 to 0111 sit next to 70 Hz
	function automatic logic [3:0] dbw_main_fix(input logic [3:0] code);
		logic [3:0] r;
		r = code;
		case (code)
			4'h8: begin
				r = code;
			end
			4'h9: begin
				r = code;
			end
			4'ha: begin
				r = code;
			end
			4'hb: begin
				r = code;
			end
			4'hc: begin
				r = code;
			end
			DBW_MAIN_HI: begin
				r = code;
			end
			4'he: begin
				r = DBW_MAIN_HI; // [R6]
			end
			DBW_MAIN_18HZ: begin
				r = code;
			end
			DBW_MAIN_35HZ: begin
				r = code;
			end
			DBW_MAIN_70HZ: begin
				r = code;
			end
			4'h2: begin
				r = DBW_MAIN_70HZ; // [R6]
			end
			4'h3: begin
				r = DBW_MAIN_70HZ; // [R6]
			end
			4'h4: begin
				r = DBW_MAIN_70HZ; // [R6]
			end
			4'h5: begin
				r = DBW_MAIN_70HZ; // [R6]
			end
			4'h6: begin
				r = DBW_MAIN_70HZ; // [R6]
			end
			4'h7: begin
				r = DBW_MAIN_70HZ; // [R6]
			end
			default: begin
				r = code;
			end
		endcase
		return r;
	endfunction

	// Request decode: an access is taken in its first access cycle only
	always_comb begin
		acc = i_psel && i_penable && !pready_ff;
		wr_acc = acc && i_pwrite && i_pstrb[0];
		rd_acc = acc && !i_pwrite;
		hit = dbw_is_mapped(i_paddr);
		wr_sec = dbw_wr_hit(wr_acc, i_paddr, DBW_ADDR_SEC_BW);
		wr_lock = dbw_wr_hit(wr_acc, i_paddr, DBW_ADDR_LOCKED_BW);
		wr_acq = dbw_wr_hit(wr_acc, i_paddr, DBW_ADDR_ACQ_BW);
		wr_sel = dbw_wr_hit(wr_acc, i_paddr, DBW_ADDR_BW_SEL);
	end

	// Register bank: unused codes are kept as written
	always_comb begin
		nxt_sec_bw = sec_bw_ff;
		nxt_lock_bw = lock_bw_ff;
		nxt_acq_bw = acq_bw_ff;
		nxt_auto_sw = auto_sw_ff;
		if (wr_sec) begin
			nxt_sec_bw = i_pwdata[1:0]; // [R1] [R6]
		end
		if (wr_lock) begin
			nxt_lock_bw = i_pwdata[3:0]; // [R2] [R6]
		end
		if (wr_acq) begin
			nxt_acq_bw = i_pwdata[3:0]; // [R3] [R4]
		end
		if (wr_sel) begin
			nxt_auto_sw = i_pwdata[DBW_AUTO_SW_BIT]; // [R5]
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sec_bw_ff <= DBW_RST_SEC_BW; // [R1]
			lock_bw_ff <= DBW_RST_LOCKED_BW;
			acq_bw_ff <= DBW_RST_ACQ_BW; // [R4]
			auto_sw_ff <= DBW_RST_AUTO_SW;
		end else begin
			sec_bw_ff <= nxt_sec_bw;
			lock_bw_ff <= nxt_lock_bw;
			acq_bw_ff <= nxt_acq_bw;
			auto_sw_ff <= nxt_auto_sw;
		end
	end

	// Bus answer: one wait state, then a single-cycle ready
	always_comb begin
		nxt_pready = acc;
		nxt_pslverr = acc && !hit;
		nxt_prdata = 32'h0;
		if (rd_acc) begin
			nxt_prdata = dbw_read_word(i_paddr, sec_bw_ff, lock_bw_ff, acq_bw_ff, auto_sw_ff); // [R6]
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			pready_ff <= 1'b0;
			prdata_ff <= 32'h0;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff <= nxt_pready;
			prdata_ff <= nxt_prdata;
			pslverr_ff <= nxt_pslverr;
		end
	end

	// Applied settings follow the bank one edge later
	always_comb begin
		use_acq = auto_sw_ff && !i_main_locked; // [R5]
		lock_eff = dbw_main_fix(lock_bw_ff); // [R2] [R6]
		acq_eff = dbw_main_fix(acq_bw_ff); // [R3] [R6]
		nxt_sec_sel = dbw_sec_fix(sec_bw_ff); // [R1]
		nxt_is_acq = use_acq;
		nxt_main_sel = use_acq ? acq_eff : lock_eff; // [R5]
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sec_sel_ff <= DBW_RST_SEC_BW;
			main_sel_ff <= DBW_MAIN_LO;
			is_acq_ff <= 1'b0;
		end else begin
			sec_sel_ff <= nxt_sec_sel;
			main_sel_ff <= nxt_main_sel;
			is_acq_ff <= nxt_is_acq;
		end
	end

	assign o_pready = pready_ff;
	assign o_prdata = prdata_ff;
	assign o_pslverr = pslverr_ff;
	assign o_secondary_loop_bw_sel = sec_sel_ff;
	assign o_main_loop_bw_sel = main_sel_ff;
	assign o_main_loop_bw_is_acquire = is_acq_ff;

endmodule

// File: sim/dbw_regs_asserts.sv
`timescale 1ns/1ps
module dbw_regs_asserts (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_main_locked,
	input wire logic o_pready,
	input wire logic [31:0] o_prdata,
	input wire logic o_pslverr,
	input wire logic [1:0] o_secondary_loop_bw_sel,
	input wire logic [3:0] o_main_loop_bw_sel,
	input wire logic o_main_loop_bw_is_acquire
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence s_acc;
		i_psel && i_penable && !o_pready;
	endsequence
	property p_ans;
		s_acc |=> o_pready;
	endproperty
	a_ans: assert property (p_ans) else $error("access not answered");
	property p_sec;
		o_secondary_loop_bw_sel != 2'h3;
	endproperty
	a_sec: assert property (p_sec) else $error("unused secondary code applied");
	property p_main;
		!(o_main_loop_bw_sel inside {[4'h2:4'h7], 4'he});
	endproperty
	a_main: assert property (p_main) else $error("unused main code applied");
	property p_lock;
		i_main_locked |=> !o_main_loop_bw_is_acquire;
	endproperty
	a_lock: assert property (p_lock) else $error("acquire bandwidth while locked");
	property p_rdz;
		o_pready |-> o_prdata[31:8] == 24'h0;
	endproperty
	a_rdz: assert property (p_rdz) else $error("unused bits not zero");
	property p_err;
		o_pslverr |-> o_pready;
	endproperty
	a_err: assert property (p_err) else $error("error outside answer");
	property p_idle;
		!o_pready |-> o_prdata == 32'h0 && !o_pslverr;
	endproperty
	a_idle: assert property (p_idle) else $error("read data outside answer");
	property p_rst;
		disable iff (1'b0) i_rst |=> !o_pready && o_secondary_loop_bw_sel == 2'h0 &&
			o_main_loop_bw_sel == 4'h8 && !o_main_loop_bw_is_acquire;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not at reset values");
endmodule
bind dbw_regs dbw_regs_asserts i_dbw_regs_asserts(.i_clk, .i_rst, .i_psel, .i_penable, .i_main_locked, .o_pready,
	.o_prdata, .o_pslverr, .o_secondary_loop_bw_sel, .o_main_loop_bw_sel, .o_main_loop_bw_is_acquire);

// File: sim/dbw_regs_test.sv
`timescale 1ns/1ps
module dbw_regs_test;
	import dbw_pkg::*;
	logic i_clk = 0, i_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, i_main_locked = 0, o_pready, o_pslverr;
	logic [11:0] i_paddr = 0;
	logic [31:0] i_pwdata = 0, rd, er, d, o_prdata;
	logic [3:0] i_pstrb = 4'hf, st;
	logic [1:0] o_secondary_loop_bw_sel;
	logic [3:0] o_main_loop_bw_sel;
	logic o_main_loop_bw_is_acquire, a;
	int n_fail = 0, n_compared = 0, seed = 32'h90aa, r, m[5] = '{0, 0, 15, 0, 0}, k[5] = '{3, 15, 15, 128, 0};
	logic [11:0] ad[5] = '{DBW_ADDR_SEC_BW, DBW_ADDR_LOCKED_BW, DBW_ADDR_ACQ_BW, DBW_ADDR_BW_SEL, 12'h004};
	dbw_regs i_dbw_regs(.i_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb,
		.o_pready, .o_prdata, .o_pslverr, .i_main_locked, .o_secondary_loop_bw_sel, .o_main_loop_bw_sel,
		.o_main_loop_bw_is_acquire);
	initial forever #25 i_clk = ~i_clk;
	function automatic logic [3:0] mp(int c);
		return (c == 14) ? 4'hd : (c > 1 && c < 8) ? 4'h1 : 4'(c);
	endfunction
	task chk(logic [31:0] g, logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task chk_sel(logic [3:0] g, int e);
		chk({28'h0, g}, e);
	endtask
	task apb(logic w, int i, logic [31:0] v, logic [3:0] s);
		i_psel <= 1;
		i_pwrite <= w;
		i_paddr <= ad[i];
		i_pwdata <= v;
		i_pstrb <= s;
		@(posedge i_clk) i_penable <= 1;
		do @(posedge i_clk); while (o_pready !== 1'b1);
		rd = o_prdata;
		er = o_pslverr;
		i_psel <= 0;
		i_penable <= 0;
		@(posedge i_clk);
	endtask
	task complete_run;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#(50 * 20000);
		n_fail++;
		complete_run;
	end
	initial begin
		repeat (6) @(posedge i_clk);
		i_rst <= 0;
		@(posedge i_clk);
		for (int j = 0; j < 80; j++) begin
			r = (j < 5) ? j : $unsigned($random(seed)) % 5;
			d = $random(seed);
			st = 4'($random(seed));
			i_main_locked <= 1'($random(seed));
			if (j >= 5) begin
				apb(1, r, d, st);
				chk(er, r == 4);
				if (r < 4 && st[0]) m[r] = d & k[r];
			end
			apb(0, r, 0, 4'h0);
			chk(rd, m[r]);
			chk(er, r == 4);
			a = m[3][7] && !i_main_locked;
			chk_sel(o_secondary_loop_bw_sel, (m[0] == 3) ? 2 : m[0]);
			chk(o_main_loop_bw_is_acquire, a);
			chk_sel(o_main_loop_bw_sel, mp(a ? m[2] : m[1]));
		end
		$display("register test done");
		i_rst <= 1;
		repeat (2) @(posedge i_clk);
		chk_sel(o_secondary_loop_bw_sel, 0);
		chk_sel(o_main_loop_bw_sel, 8);
		chk(o_main_loop_bw_is_acquire, 0);
		i_rst <= 0;
		m = '{0, 0, 15, 0, 0};
		@(posedge i_clk);
		for (int j = 0; j < 5; j++) begin
			apb(0, j, 0, 4'h0);
			chk(rd, m[j]);
		end
		$display("reset test done");
		complete_run;
	end
endmodule
